// ---- core/rsp_port.sv ----
// serial slave port: header decode, register file, burst counter, strobes
`timescale 1ns/10ps
`include "rsp_cfg.svh"
module rsp_port (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// serial pins
	input  wire logic        sclk_in,
	input  wire logic        select_low_in,
	input  wire logic        mosi_in,
	output logic             miso_out,
	output logic             miso_oe_low_out,
	// core side
	input  wire logic        crystal_off_state_in,
	input  wire logic        crystal_ready_low_in,
	input  wire logic [6:0]  status_bits_in,
	input  wire logic [7:0]  status_reg_data_in,
	output logic [5:0]       status_reg_addr_out,
	output logic             strobe_out,
	output logic [5:0]       strobe_addr_out,
	output logic             abort_out,
	output logic [7:0]       cfg_flat_out [`RSP_NUM_REGS]
);
	rsp_sync_if sync ();
	rsp_pin_sync u_sync (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.sclk_in       (sclk_in),
		.select_low_in (select_low_in),
		.mosi_in       (mosi_in),
		.sync          (sync)
	);

	rsp_pkg::rsp_state_type state_r;
	logic        sclk_d_r;
	logic        sel_d_r;
	logic        rise;
	logic        fall;
	logic        sel_fall;
	logic [2:0]  bit_r;
	logic [7:0]  rx_r;
	logic [7:0]  tx_r;
	logic [7:0]  rx_byte;
	logic        rw_r;
	logic        burst_r;
	logic [5:0]  addr_r;
	logic        load_r;
	logic        miso_r;
	logic [7:0]  regs_r [`RSP_NUM_REGS];
	logic [7:0]  status_byte;
	logic        byte_done;

	function automatic logic is_status_range(input logic [5:0] a);
		is_status_range = (a >= `RSP_STAT_LO) && (a <= `RSP_STAT_HI);
	endfunction : is_status_range

	function automatic logic is_cfg(input logic [5:0] a);
		is_cfg = (a <= `RSP_CFG_LAST);
	endfunction : is_cfg

	assign rise        = sync.sclk & ~sclk_d_r;
	assign fall        = ~sync.sclk & sclk_d_r;
	assign sel_fall    = ~sync.sel_low & sel_d_r;
	assign rx_byte     = {rx_r[6:0], sync.mosi};
	assign byte_done   = rise && (bit_r == 3'h7);
	assign status_byte = {crystal_ready_low_in, status_bits_in};

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sclk_d_r <= 1'b0;
			sel_d_r  <= 1'b1;
		end else begin
			sclk_d_r <= sync.sclk;
			sel_d_r  <= sync.sel_low;
		end
	end

	// framing: select high at any point abandons the transfer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r <= rsp_pkg::RSP_IDLE;
		end else if (sync.sel_low) begin
			state_r <= rsp_pkg::RSP_IDLE;
		end else begin
			unique case (state_r)
				rsp_pkg::RSP_IDLE:   if (sel_fall) state_r <= rsp_pkg::RSP_HEADER;
				rsp_pkg::RSP_HEADER: if (byte_done) state_r <= rsp_pkg::RSP_DATA;
				rsp_pkg::RSP_DATA:   state_r <= rsp_pkg::RSP_DATA;
			endcase
		end
	end

	// input shifter, rising edge sampling
	always_ff @(posedge clk_in) begin
		if (rst_in || state_r == rsp_pkg::RSP_IDLE) begin
			bit_r <= 3'h0;
			rx_r  <= 8'h00;
		end else if (rise) begin
			bit_r <= bit_r + 3'h1;
			rx_r  <= rx_byte;
		end
	end

	// header capture and burst address counter
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rw_r    <= 1'b0;
			burst_r <= 1'b0;
			addr_r  <= 6'h00;
		end else if (byte_done && state_r == rsp_pkg::RSP_HEADER) begin
			rw_r    <= rx_byte[`RSP_HDR_RW_BIT];
			burst_r <= rx_byte[`RSP_HDR_BURST_BIT];
			addr_r  <= rx_byte[`RSP_ADDR_W-1:0];
		end else if (byte_done && state_r == rsp_pkg::RSP_DATA && burst_r) begin
			addr_r  <= addr_r + 6'h01;
		end
	end

	// command strobe when the header hits the status range without burst
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			strobe_out      <= 1'b0;
			strobe_addr_out <= 6'h00;
		end else begin
			strobe_out <= byte_done && state_r == rsp_pkg::RSP_HEADER
				&& !rx_byte[`RSP_HDR_BURST_BIT]
				&& is_status_range(rx_byte[`RSP_ADDR_W-1:0]);
			if (byte_done && state_r == rsp_pkg::RSP_HEADER)
				strobe_addr_out <= rx_byte[`RSP_ADDR_W-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			abort_out <= 1'b0;
		else
			abort_out <= sync.sel_low && sel_d_r == 1'b0 && state_r != rsp_pkg::RSP_IDLE
				&& bit_r != 3'h0;
	end

	// register file; writes only at a completed data byte
	genvar g;
	generate
		for (g = 0; g < `RSP_NUM_REGS; g++) begin : g_reg
			always_ff @(posedge clk_in) begin
				if (rst_in)
					regs_r[g] <= `RSP_REG_RESET;
				else if (byte_done && state_r == rsp_pkg::RSP_DATA && !rw_r
					&& addr_r == 6'(g) && !sync.sel_low)
					regs_r[g] <= rx_byte;
			end
			assign cfg_flat_out[g] = regs_r[g];
		end
	endgenerate

	assign status_reg_addr_out = addr_r;

	// next byte to send: status after header/write, register data after read header
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			load_r <= 1'b0;
		end else begin
			load_r <= byte_done;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_r <= 8'h00;
		end else if (sel_fall) begin
			tx_r <= status_byte;
		end else if (load_r) begin
			if (!rw_r)
				tx_r <= status_byte;
			else if (is_cfg(addr_r))
				tx_r <= regs_r[addr_r];
			else if (is_status_range(addr_r) && burst_r)
				tx_r <= status_reg_data_in;
			else
				tx_r <= 8'h00;
		end else if (fall && bit_r != 3'h0) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	// output: low right after select falls when the crystal runs and shows ready
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			miso_r <= 1'b1;
		end else if (sync.sel_low) begin
			miso_r <= 1'b1;
		end else if (sel_fall) begin
			miso_r <= crystal_off_state_in | crystal_ready_low_in;
		end else if (state_r == rsp_pkg::RSP_HEADER && bit_r == 3'h0 && !load_r) begin
			miso_r <= crystal_ready_low_in;
		end else if (fall) begin
			// first fall of a byte shows the loaded msb, later falls the next bit
			miso_r <= (bit_r == 3'h0) ? tx_r[7] : tx_r[6];
		end
	end

	assign miso_out        = miso_r;
	assign miso_oe_low_out = sync.sel_low;

	// assertions
	AST_ADDR_INC: assert property (@(posedge clk_in) disable iff (rst_in)
		(byte_done && state_r == rsp_pkg::RSP_DATA && burst_r && !sync.sel_low)
		|=> addr_r == $past(addr_r) + 6'h01)
		else $error("burst address did not step");
	AST_ABANDON: assert property (@(posedge clk_in) disable iff (rst_in)
		sync.sel_low |=> state_r == rsp_pkg::RSP_IDLE)
		else $error("transfer kept after select release");
	AST_READY_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
		(sel_fall && !crystal_off_state_in && !crystal_ready_low_in) |=> !miso_r)
		else $error("output not low after select");
	AST_STROBE: assert property (@(posedge clk_in) disable iff (rst_in)
		strobe_out |-> is_status_range(strobe_addr_out) && !burst_r)
		else $error("strobe outside status range");
	AST_HDR: assert property (@(posedge clk_in) disable iff (rst_in)
		(byte_done && state_r == rsp_pkg::RSP_HEADER) |=> rw_r == $past(rx_byte[7]))
		else $error("header flag misplaced");
	AST_SAMPLE: assert property (@(posedge clk_in) disable iff (rst_in)
		(rise && state_r != rsp_pkg::RSP_IDLE && !sync.sel_low) |=> rx_r[0] == $past(sync.mosi))
		else $error("input not sampled on rise");
	AST_MSB: assert property (@(posedge clk_in) disable iff (rst_in)
		(rise && state_r != rsp_pkg::RSP_IDLE && !sync.sel_low) |=> rx_r[7:1] == $past(rx_r[6:0]))
		else $error("shift order wrong");
	AST_RESET: assert property (@(posedge clk_in)
		rst_in |=> regs_r[0] == `RSP_REG_RESET)
		else $error("register not at default");
	AST_HEADER_STATE: assert property (@(posedge clk_in) disable iff (rst_in)
		(sel_fall) |=> state_r == rsp_pkg::RSP_HEADER)
		else $error("header phase missed");
	AST_STATUS_OUT: assert property (@(posedge clk_in) disable iff (rst_in)
		(load_r && !rw_r && !sync.sel_low) |=> tx_r == $past(status_byte))
		else $error("status byte not loaded");
	AST_BURST_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_r == rsp_pkg::RSP_DATA && $past(state_r) == rsp_pkg::RSP_DATA) |-> $stable(rw_r))
		else $error("burst direction changed");

	COV_WRITE: cover property (@(posedge clk_in) byte_done && state_r == rsp_pkg::RSP_DATA && !rw_r);
	COV_READ: cover property (@(posedge clk_in) byte_done && state_r == rsp_pkg::RSP_DATA && rw_r);
	COV_STROBE: cover property (@(posedge clk_in) strobe_out);
	COV_ABORT: cover property (@(posedge clk_in) abort_out);
endmodule : rsp_port

// ---- core/rsp_cfg.svh ----
// constants for the radio serial configuration port
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH
`define RSP_HDR_RW_BIT      7
`define RSP_HDR_BURST_BIT   6
`define RSP_ADDR_W          6
`define RSP_STAT_LO         6'h30
`define RSP_STAT_HI         6'h3d
`define RSP_CFG_LAST        6'h2e
`define RSP_NUM_REGS        47
`define RSP_REG_RESET       8'h00
`define RSP_SYNC_STAGES     3
`define RSP_WAKE_WAIT_NS    150000
`endif

// ---- core/rsp_pkg.sv ----
// types for the radio serial configuration port
package rsp_pkg;
	typedef enum logic [1:0] {
		RSP_IDLE,
		RSP_HEADER,
		RSP_DATA
	} rsp_state_type;
endpackage : rsp_pkg

// ---- core/rsp_sync_if.sv ----
// synchronised pin levels passed from the sampler to the port core
`timescale 1ns/10ps
interface rsp_sync_if;
	logic sclk;
	logic sel_low;
	logic mosi;
	modport src (output sclk, output sel_low, output mosi);
	modport dst (input sclk, input sel_low, input mosi);
endinterface : rsp_sync_if

// ---- core/rsp_pin_sync.sv ----
// three-stage pin sampler with agreement filter
`timescale 1ns/10ps
`include "rsp_cfg.svh"
module rsp_pin_sync (
	// clock and reset
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	// raw pins
	input  wire logic  sclk_in,
	input  wire logic  select_low_in,
	input  wire logic  mosi_in,
	// clean levels
	rsp_sync_if.src    sync
);
	logic [2:0] pins;
	logic [2:0] st_r [`RSP_SYNC_STAGES];
	logic [2:0] clean_r;

	assign pins = {sclk_in, select_low_in, mosi_in};

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r[0] <= 3'h2;
			st_r[1] <= 3'h2;
			st_r[2] <= 3'h2;
		end else begin
			st_r[0] <= pins;
			st_r[1] <= st_r[0];
			st_r[2] <= st_r[1];
		end
	end

	// a bit changes only once the second and third stage agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_flt
			always_ff @(posedge clk_in) begin
				if (rst_in)
					clean_r[g] <= (g == 1);
				else if (st_r[1][g] == st_r[2][g])
					clean_r[g] <= st_r[2][g];
			end
		end
	endgenerate

	assign sync.sclk    = clean_r[2];
	assign sync.sel_low = clean_r[1];
	assign sync.mosi    = clean_r[0];
endmodule : rsp_pin_sync

// ---- verif/rsp_host_model.sv ----
// host-side serial master model driving the port pins
`timescale 1ns/10ps
module rsp_host_model (
	// serial pins
	output logic      sclk_out,
	output logic      select_low_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	initial begin
		sclk_out = 1'b0;
		select_low_out = 1'b1;
		mosi_out = 1'b0;
	end
	// no clock while polling for ready on the port output, giving up after 12 polls of 100 ns
	task automatic open_frame(output bit ready);
		int n;
		select_low_out = 1'b0;
		ready = 1'b0;
		for (n = 0; n < 12 && !ready; n++) begin
			#100;
			ready = (miso_in === 1'b0);
		end
	endtask : open_frame
	// output bit sampled late in the high phase, as it settles some cycles after the fall
	task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		for (i = 7; i > 7 - nbits; i--) begin
			mosi_out = tx[i];
			#400 sclk_out = 1'b1;
			#390 rx[i] = miso_in;
			#10 sclk_out = 1'b0;
		end
		mosi_out = ~mosi_out;
	endtask : shift
	task automatic close_frame();
		#400 select_low_out = 1'b1;
		mosi_out = ~mosi_out;
		#800;
	endtask : close_frame
endmodule : rsp_host_model

// ---- verif/test_rsp_port.sv ----
// self-checking bench for the serial configuration port
`timescale 1ns/10ps
`include "rsp_cfg.svh"
module test_rsp_port;
	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       sclk, sel_low, mosi, miso, strobe, abort;
	logic       rdy_low = 1'b0;
	logic       crystal_off_state = 1'b0;
	logic       oe_low;
	logic [6:0] stat_bits = 7'h00;
	logic [7:0] stat_data = 8'h00;
	logic [5:0] stat_addr, strobe_addr, last_strobe, a;
	logic [7:0] cfg [`RSP_NUM_REGS];
	logic [7:0] exp_regs [`RSP_NUM_REGS];
	logic [7:0] dat [8];
	logic [7:0] got [8];
	int         fails = 0, tests_run = 0, seed = 46, strobes = 0, aborts = 0, i, k;
	bit         ok;

	always #50 clk_in = ~clk_in;

	rsp_port rsp_port_inst (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
		.select_low_in(sel_low), .mosi_in(mosi), .miso_out(miso), .miso_oe_low_out(oe_low),
		.crystal_off_state_in(crystal_off_state), .crystal_ready_low_in(rdy_low),
		.status_bits_in(stat_bits), .status_reg_data_in(stat_data),
		.status_reg_addr_out(stat_addr), .strobe_out(strobe),
		.strobe_addr_out(strobe_addr), .abort_out(abort), .cfg_flat_out(cfg));
	rsp_host_model rsp_host_model_inst (.sclk_out(sclk), .select_low_out(sel_low),
		.mosi_out(mosi), .miso_in(miso));

	always @(posedge clk_in) begin
		if (strobe === 1'b1) begin
			strobes++;
			last_strobe = strobe_addr;
		end
		if (abort === 1'b1)
			aborts++;
	end

	task automatic check(input logic [7:0] g, input logic [7:0] w, input string what);
		tests_run++;
		if (g !== w) begin
			fails++;
			$display("MISMATCH %0t %s got %h want %h", $time, what, g, w);
		end
	endtask : check

	function automatic logic [7:0] stat_exp();
		return {rdy_low, stat_bits};
	endfunction : stat_exp

	// header plus n whole bytes; status byte checked on the header
	task automatic access(input logic rw, input logic bst, input logic [5:0] ad, input int n);
		logic [7:0] st;
		int j;
		stat_bits = 7'($random(seed));
		rsp_host_model_inst.open_frame(ok);
		check({7'h00, ok}, 8'h01, "ready");
		check({7'h00, oe_low}, 8'h00, "drive");
		rsp_host_model_inst.shift({rw, bst, ad}, 8, st);
		check(st, stat_exp(), "status");
		for (j = 0; j < n; j++) begin
			rsp_host_model_inst.shift(dat[j], 8, got[j]);
			if (!rw)
				check(got[j], stat_exp(), "write status");
		end
		rsp_host_model_inst.close_frame();
		check({7'h00, oe_low}, 8'h01, "release");
	endtask : access

	task automatic all_regs();
		for (i = 0; i < `RSP_NUM_REGS; i++)
			check(cfg[i], exp_regs[i], "reg");
	endtask : all_regs

	task automatic stop_test();
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	initial begin
		#2_000_000;
		fails++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge clk_in);
		#5 rst_in = 1'b0;
		for (i = 0; i < `RSP_NUM_REGS; i++)
			exp_regs[i] = `RSP_REG_RESET;
		all_regs();
		for (k = 0; k < 16; k++) begin
			a = 6'(($random(seed) & 32'h7fff_ffff) % `RSP_NUM_REGS);
			dat[0] = 8'($random(seed));
			access(1'b0, 1'b0, a, 1);
			exp_regs[a] = dat[0];
		end
		for (k = 0; k < 8; k++)
			dat[k] = 8'($random(seed));
		access(1'b0, 1'b1, 6'h27, 8);
		for (k = 0; k < 8; k++)
			exp_regs[6'h27 + k] = dat[k];
		dat[0] = 8'h5a;
		access(1'b0, 1'b0, 6'h2f, 1);
		all_regs();
		access(1'b1, 1'b1, 6'h00, 8);
		for (k = 0; k < 8; k++)
			check(got[k], exp_regs[k], "burst read");
		access(1'b1, 1'b0, a, 1);
		check(got[0], exp_regs[a], "read");
		for (a = 6'h30; a <= 6'h3d; a++) begin
			k = strobes;
			access(1'($random(seed)), 1'b0, a, 0);
			check(8'(strobes - k), 8'h01, "strobe count");
			check({2'h0, last_strobe}, {2'h0, a}, "strobe addr");
			stat_data = 8'($random(seed));
			access(1'b1, 1'b1, a, 1);
			check(got[0], stat_data, "status reg");
			check({2'h0, stat_addr}, {2'h0, a + 6'h01}, "status addr");
		end
		for (k = 0; k < 2; k++) begin
			i = aborts;
			rsp_host_model_inst.open_frame(ok);
			rsp_host_model_inst.shift(8'h05, k == 0 ? 3 : 8, dat[1]);
			if (k == 1)
				rsp_host_model_inst.shift(~exp_regs[5], 4, dat[1]);
			rsp_host_model_inst.close_frame();
			check(8'(aborts - i), 8'h01, "abort");
			check(cfg[5], exp_regs[5], "abandoned");
		end
		// crystal off: no ready shown, so the host falls back to the blind wake wait
		crystal_off_state = 1'b1;
		rdy_low = 1'b1;
		rsp_host_model_inst.open_frame(ok);
		check({7'h00, ok}, 8'h00, "asleep");
		crystal_off_state = 1'b0;
		rdy_low = 1'b0;
		#(`RSP_WAKE_WAIT_NS);
		check({7'h00, miso}, 8'h00, "awake");
		rsp_host_model_inst.close_frame();
		// second reset in mid-run must reload every default
		rst_in = 1'b1;
		repeat (6) @(posedge clk_in);
		#5 rst_in = 1'b0;
		for (i = 0; i < `RSP_NUM_REGS; i++)
			exp_regs[i] = `RSP_REG_RESET;
		all_regs();
		dat[0] = 8'($random(seed));
		access(1'b0, 1'b0, 6'h05, 1);
		exp_regs[5] = dat[0];
		all_regs();
		stop_test();
	end
endmodule : test_rsp_port
